/* src/sram_port_pkg.sv */
// Constants and carrier types for the host-side controller of a 16-bit asynchronous non-volatile static RAM.
// Assumes a 50 MHz system clock and a device wired directly to the pin-level outputs of the controller.
// Summary of operation
// - Write strobe stays high throughout every read cycle.
// - Hardware save request line stays high during every read and write.
// - Chip enable low at least 15 ns before write ends.
// - Byte select asserted at least 15 ns before write ends.
// - Write data presented at least 5 ns before write ends.
// - Write data held valid until the write ends.
// - Address stable at least 10 ns before write ends.
// - Address set up no later than write strobe start.
package sram_port_pkg;

  localparam int CLK_PERIOD_NS      = 20;
  localparam int ADDR_W             = 18;
  localparam int DATA_W             = 16;

  // Fastest grade figures in ns.
  localparam int READ_CYCLE_NS      = 15;
  localparam int CE_ACCESS_NS       = 15;
  localparam int OE_ACCESS_NS       = 10;
  localparam int BYTE_ACCESS_NS     = 10;
  localparam int OUT_FLOAT_NS       = 7;
  localparam int WRITE_CYCLE_NS     = 15;
  localparam int WRITE_PULSE_NS     = 10;
  localparam int CE_TO_WEND_NS      = 15;
  localparam int BYTE_TO_WEND_NS    = 15;
  localparam int DATA_SETUP_NS      = 5;
  localparam int ADDR_TO_WEND_NS    = 10;
  localparam int OUT_ACTIVE_AFTER_W_NS = 3;
  // Power-up restore time in ms and save duration in ms (tenths, 12.5 ms = 125).
  localparam int POWERUP_RESTORE_MS = 20;
  localparam int SAVE_DURATION_TENTH_MS = 125;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  // Read: data is sampled after the slower of the chip enable and output enable access paths, plus one cycle of pin-sync margin.
  localparam int READ_ACCESS_NS     = (CE_ACCESS_NS > OE_ACCESS_NS) ? CE_ACCESS_NS : OE_ACCESS_NS;
  localparam int READ_CYC           = cyc_min(READ_ACCESS_NS) + 1;
  localparam int FLOAT_CYC          = cyc_min(OUT_FLOAT_NS);
  localparam int WPULSE_NS_MAX      = (WRITE_PULSE_NS > CE_TO_WEND_NS) ? WRITE_PULSE_NS : CE_TO_WEND_NS;
  localparam int WRITE_CYC          = cyc_min((WPULSE_NS_MAX > ADDR_TO_WEND_NS) ? WPULSE_NS_MAX : ADDR_TO_WEND_NS);
  localparam int RECOVER_CYC        = cyc_min(OUT_ACTIVE_AFTER_W_NS);
  localparam int RESTORE_CYC        = POWERUP_RESTORE_MS * (1000000 / CLK_PERIOD_NS);
  localparam int SAVE_CYC           = SAVE_DURATION_TENTH_MS * (100000 / CLK_PERIOD_NS);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic [1:0]        lanes;
  } req_type;

  typedef struct packed {
    logic              chip_en_n;
    logic              out_en_n;
    logic              write_n;
    logic              low_lane_select_n;
    logic              high_lane_select_n;
    logic              hw_save_request_n;
  } strobe_type;

endpackage : sram_port_pkg

/* src/pin_sync.sv */
// Three-stage synchroniser with agreement filter for levels arriving from outside the clock domain.
// Assumes the input is a slow level; the output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s2_ff[i];
        end
      end
    end
  end

  assign level_o = lvl_ff;
endmodule : pin_sync

/* src/sram_host_ctrl.sv */
// Host-side controller that runs single word or byte reads and writes on an asynchronous 16-bit static RAM.
// Assumes the device is wired pin for pin; the supply monitor output arrives as a level from outside the domain.
`timescale 1ns/1ps
module sram_host_ctrl #(
  parameter int RESTORE_CYC = sram_port_pkg::RESTORE_CYC,
  parameter int SAVE_CYC    = sram_port_pkg::SAVE_CYC
) (
  input  wire logic                              clock_i,
  input  wire logic                              rst_i,
  input  wire logic                              req_valid_i,
  input  wire sram_port_pkg::req_type            req_i,
  output logic                                   req_ready_o,
  output logic                                   rsp_valid_o,
  output logic [sram_port_pkg::DATA_W-1:0]       rsp_data_o,
  input  wire logic                              power_good_i,
  output logic                                   mem_busy_o,
  output logic [sram_port_pkg::ADDR_W-1:0]       addr_o,
  output sram_port_pkg::strobe_type              strobe_o,
  output logic [sram_port_pkg::DATA_W-1:0]       data_io_o,
  output logic [sram_port_pkg::DATA_W-1:0]       data_io_oe_o,
  input  wire logic [sram_port_pkg::DATA_W-1:0]  data_io_i
);

  typedef enum logic [2:0] {IDLE, SETUP, RD_WAIT, WR_PULSE, RECOVER, PWR_WAIT} state_type;

  localparam int CW = 32;
  localparam sram_port_pkg::strobe_type STB_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  state_type                      state_ff;
  state_type                      nxt_state;
  logic [CW-1:0]                  cnt_ff;
  logic [CW-1:0]                  nxt_cnt;
  sram_port_pkg::req_type         cur_ff;
  sram_port_pkg::strobe_type      stb_ff;
  sram_port_pkg::strobe_type      nxt_stb;
  logic [sram_port_pkg::ADDR_W-1:0] addr_ff;
  logic [sram_port_pkg::DATA_W-1:0] dout_ff;
  logic [sram_port_pkg::DATA_W-1:0] oe_ff;
  logic [sram_port_pkg::DATA_W-1:0] nxt_oe;
  logic [sram_port_pkg::DATA_W-1:0] rdata_ff;
  logic                           rsp_ff;
  logic                           ready_ff;
  logic                           busy_ff;
  logic                           dirty_ff;
  logic                           pwr_prev_ff;
  logic                           pwr_ok;
  logic [sram_port_pkg::DATA_W-1:0] din_sync;
  logic                           cnt_done;
  logic                           take;
  logic                           pwr_rise;
  logic                           pwr_fall;
  logic [sram_port_pkg::DATA_W-1:0] lane_mask;

  // The read bus is sampled through the same filter as any pin, trading four cycles of latency for safety.
  pin_sync #(.W(sram_port_pkg::DATA_W + 1)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({power_good_i, data_io_i}),
    .level_o ({pwr_ok, din_sync})
  );

  // Ready is registered and cleared by a take, so requests are never accepted back to back.
  // A request is taken only in IDLE, which keeps the address still while any strobe is active.
  assign cnt_done  = (cnt_ff == '0);
  assign take      = (state_ff == IDLE) && req_valid_i && ready_ff;
  assign pwr_rise  = pwr_ok && !pwr_prev_ff;
  assign pwr_fall  = !pwr_ok && pwr_prev_ff;
  assign lane_mask = {{8{cur_ff.lanes[1]}}, {8{cur_ff.lanes[0]}}};

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 1'b1;
    nxt_stb   = stb_ff;
    nxt_oe    = oe_ff;
    case (state_ff)
      IDLE: begin
        nxt_stb = STB_IDLE;
        nxt_oe  = '0;
        if (take) begin
          nxt_state = SETUP;
          nxt_cnt   = '0;
        end
      end
      SETUP: begin
        nxt_stb.hw_save_request_n  = 1'b1;
        nxt_stb.chip_en_n          = 1'b0;
        nxt_stb.low_lane_select_n  = !cur_ff.lanes[0];
        nxt_stb.high_lane_select_n = !cur_ff.lanes[1];
        if (cur_ff.write) begin
          nxt_stb.write_n  = 1'b0;
          nxt_stb.out_en_n = 1'b1;
          nxt_oe    = lane_mask;
          nxt_state = WR_PULSE;
          nxt_cnt   = CW'(sram_port_pkg::WRITE_CYC - 1);
        end else begin
          nxt_stb.write_n  = 1'b1;
          nxt_stb.out_en_n = 1'b0;
          nxt_state = RD_WAIT;
          nxt_cnt   = CW'(sram_port_pkg::READ_CYC + 2);
        end
      end
      RD_WAIT: begin
        if (cnt_done) begin
          nxt_stb   = STB_IDLE;
          nxt_state = RECOVER;
          nxt_cnt   = CW'(sram_port_pkg::FLOAT_CYC);
        end
      end
      WR_PULSE: begin
        if (cnt_done) begin
          nxt_stb.write_n   = 1'b1;
          nxt_stb.chip_en_n = 1'b1;
          nxt_stb.low_lane_select_n  = 1'b1;
          nxt_stb.high_lane_select_n = 1'b1;
          nxt_state = RECOVER;
          nxt_cnt   = CW'(sram_port_pkg::RECOVER_CYC);
        end
      end
      RECOVER: begin
        nxt_oe = '0;
        if (cnt_done) begin
          nxt_state = IDLE;
        end
      end
      PWR_WAIT: begin
        nxt_stb = STB_IDLE;
        nxt_oe  = '0;
        if (cnt_done && pwr_ok) begin
          nxt_state = IDLE;
        end
      end
      default: begin
        nxt_state = IDLE;
        nxt_stb   = STB_IDLE;
        nxt_oe    = '0;
      end
    endcase
    // A power event overrides any cycle in flight and returns the strobes to idle at once.
    // The device ignores accesses below its trigger level, so an aborted cycle loses nothing more.
    // no cycles in power events
    if (pwr_fall || (!pwr_ok && state_ff != PWR_WAIT)) begin
      nxt_state = PWR_WAIT;
      nxt_stb   = STB_IDLE;
      nxt_oe    = '0;
      nxt_cnt   = dirty_ff ? CW'(SAVE_CYC) : '0;
    end else if (pwr_rise) begin
      nxt_state = PWR_WAIT;
      nxt_cnt   = CW'(RESTORE_CYC);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff    <= PWR_WAIT;
      cnt_ff      <= '0;
      stb_ff      <= STB_IDLE;
      oe_ff       <= '0;
      pwr_prev_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      stb_ff      <= nxt_stb;
      oe_ff       <= nxt_oe;
      pwr_prev_ff <= pwr_ok;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cur_ff   <= '0;
      addr_ff  <= '0;
      dout_ff  <= '0;
      rdata_ff <= '0;
      rsp_ff   <= 1'b0;
      ready_ff <= 1'b0;
      busy_ff  <= 1'b1;
      dirty_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_state == IDLE) && !take;
      busy_ff  <= (nxt_state == PWR_WAIT);
      // The answer pulse marks the edge at which the read word is captured, unless power failed then.
      rsp_ff   <= (state_ff == RD_WAIT) && cnt_done && (nxt_state == RECOVER);
      if (take) begin
        cur_ff  <= req_i;
        addr_ff <= req_i.addr;
        dout_ff <= req_i.wdata;
      end
      if ((state_ff == RD_WAIT) && cnt_done) begin
        rdata_ff <= din_sync & lane_mask;
      end
      // Only a completed write pulse marks the array as changed since the last save or restore.
      if ((state_ff == WR_PULSE) && cnt_done) begin
        dirty_ff <= 1'b1;
      end else if ((state_ff == PWR_WAIT) && cnt_done && pwr_ok) begin
        dirty_ff <= 1'b0;
      end
    end
  end

  assign req_ready_o  = ready_ff;
  assign rsp_valid_o  = rsp_ff;
  assign rsp_data_o   = rdata_ff;
  assign mem_busy_o   = busy_ff;
  assign addr_o       = addr_ff;
  assign strobe_o     = stb_ff;
  assign data_io_o    = dout_ff;
  assign data_io_oe_o = oe_ff;

endmodule : sram_host_ctrl

/* tb/sram_device_model.sv */
// Behavioural model of the asynchronous 16-bit non-volatile static RAM.
// Assumes the bench resolves the shared data wire and feeds it back on data_i.
`timescale 1ns/1ps
module sram_device_model #(
  parameter int SAVE_NS    = 200,
  parameter int RESTORE_NS = 400
) (
  input  wire logic [sram_port_pkg::ADDR_W-1:0] addr_i,
  input  wire sram_port_pkg::strobe_type        strobe_i,
  input  wire logic [sram_port_pkg::DATA_W-1:0] data_i,
  input  wire logic                             power_good_i,
  output logic      [sram_port_pkg::DATA_W-1:0] data_o,
  output logic      [sram_port_pkg::DATA_W-1:0] data_oe_o
);
  logic [15:0] mem   [0:262143];
  logic [15:0] saved [0:262143];
  logic        locked = 1'b1;
  logic        dirty  = 1'b0;
  logic [15:0] mask;
  logic        sel;
  initial foreach (saved[i]) saved[i] = 16'h0000;
  assign mask = {{8{!strobe_i.high_lane_select_n}}, {8{!strobe_i.low_lane_select_n}}};
  assign sel = !strobe_i.chip_en_n && strobe_i.hw_save_request_n && !locked;
  assign #7 data_oe_o = (sel && !strobe_i.out_en_n && strobe_i.write_n) ? mask : 16'h0000;
  assign #7 data_o = mem[addr_i];
  always @(strobe_i or addr_i or data_i) begin
    if (sel && !strobe_i.write_n) begin
      mem[addr_i] = (mem[addr_i] & ~mask) | (data_i & mask);
      dirty = 1'b1;
    end
  end
  always @(negedge power_good_i) begin
    locked = 1'b1;
    if (dirty) begin
      #(SAVE_NS);
      saved = mem;
      dirty = 1'b0;
    end
  end
  always @(posedge power_good_i) begin
    #(RESTORE_NS);
    mem = saved;
    locked = 1'b0;
  end
endmodule : sram_device_model

/* tb/sram_host_ctrl_monitor.sv */
// Concurrent checks on the pin side and the request handshake of the host controller.
// Assumes binding into sram_host_ctrl; everything is sampled on clock_i.
`timescale 1ns/1ps
module sram_host_ctrl_monitor (
  input wire logic                             clock_i,
  input wire logic                             rst_i,
  input wire logic                             req_valid_i,
  input wire logic                             req_ready_o,
  input wire logic                             rsp_valid_o,
  input wire logic                             mem_busy_o,
  input wire logic [sram_port_pkg::ADDR_W-1:0] addr_o,
  input wire sram_port_pkg::strobe_type        strobe_o,
  input wire logic [sram_port_pkg::DATA_W-1:0] data_io_o,
  input wire logic [sram_port_pkg::DATA_W-1:0] data_io_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence write_end;
    $rose(strobe_o.write_n);
  endsequence
  sequence read_start;
    $fell(strobe_o.out_en_n);
  endsequence
  // Five sampled cycles of read strobes with no early answer, then a one-cycle answer.
  sequence read_hold;
    (!strobe_o.chip_en_n && !strobe_o.out_en_n && !rsp_valid_o)[*5];
  endsequence
  sequence read_reply;
    rsp_valid_o ##1 !rsp_valid_o;
  endsequence
  a_read_write_high: assert property (!strobe_o.out_en_n |-> strobe_o.write_n)
    else $error("write strobe low in a read");
  a_save_line_high: assert property (strobe_o.hw_save_request_n)
    else $error("save request line driven low");
  a_ce_before_wend: assert property (write_end |-> $past(!strobe_o.chip_en_n))
    else $error("chip enable not low before write end");
  a_lane_before_wend: assert property (write_end |-> $past(!strobe_o.low_lane_select_n || !strobe_o.high_lane_select_n))
    else $error("no lane selected before write end");
  a_data_on_lanes: assert property (!strobe_o.write_n |-> data_io_oe_o == {{8{!strobe_o.high_lane_select_n}},
    {8{!strobe_o.low_lane_select_n}}})
    else $error("write data not driven on selected lanes");
  a_data_hold_wend: assert property (write_end |-> $stable(data_io_o) && $stable(data_io_oe_o))
    else $error("write data released at write end");
  a_addr_wend: assert property (write_end |-> $stable(addr_o))
    else $error("address moved at write end");
  a_addr_wstart: assert property (!strobe_o.write_n |-> $stable(addr_o))
    else $error("address moved during write pulse");
  a_addr_idle_move: assert property ($changed(addr_o) |-> $past(strobe_o.chip_en_n) || $past(strobe_o.write_n))
    else $error("address moved during active write");
  a_cycle_gap: assert property ($rose(strobe_o.chip_en_n) |=> strobe_o.chip_en_n)
    else $error("cycles not spaced");
  a_read_answer: assert property (read_start |-> read_hold ##1 read_reply)
    else $error("read strobes or answer out of step");
  a_busy_no_cycle: assert property (mem_busy_o |-> strobe_o.chip_en_n && !req_ready_o)
    else $error("access while power event pending");
  a_ready_drop: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("ready held after take");
endmodule : sram_host_ctrl_monitor
bind sram_host_ctrl sram_host_ctrl_monitor i_sram_host_ctrl_monitor (.clock_i(clock_i), .rst_i(rst_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .mem_busy_o(mem_busy_o),
  .addr_o(addr_o), .strobe_o(strobe_o), .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o));

/* tb/sram_host_ctrl_bench.sv */
// Self-checking bench: random and corner reads and writes, then two power cycles.
// Assumes shortened save and restore counts; the model's delays match them.
`timescale 1ns/1ps
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module sram_host_ctrl_bench;
  logic                      clock_i      = 1'b0;
  logic                      rst_i        = 1'b1;
  logic                      req_valid_i  = 1'b0;
  logic                      power_good_i = 1'b0;
  sram_port_pkg::req_type    req_i        = '0;
  logic                      req_ready_o, rsp_valid_o, mem_busy_o;
  logic [15:0]               rsp_data_o, data_io_o, data_io_oe_o, dev_data, dev_oe, wire_q;
  logic [15:0]               float_q      = 16'h5a5a;
  logic [17:0]               addr_o;
  sram_port_pkg::strobe_type strobe_o;
  logic [15:0]               shadow [logic [17:0]];
  int                        failures, checks_done, cycles, seed = 38924;
  always #10 clock_i = ~clock_i;
  // A floating lane shows a changing pattern, never the last driven value.
  always @(posedge clock_i) float_q <= ~float_q;
  assign wire_q = (data_io_o & data_io_oe_o) | (dev_data & dev_oe) | (float_q & ~data_io_oe_o & ~dev_oe);
  sram_host_ctrl #(.RESTORE_CYC(20), .SAVE_CYC(10)) i_sram_host_ctrl (.clock_i(clock_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .power_good_i(power_good_i), .mem_busy_o(mem_busy_o), .addr_o(addr_o),
    .strobe_o(strobe_o), .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o), .data_io_i(wire_q));
  sram_device_model #(.SAVE_NS(200), .RESTORE_NS(400)) i_sram_device_model (.addr_i(addr_o),
    .strobe_i(strobe_o), .data_i(wire_q), .power_good_i(power_good_i), .data_o(dev_data), .data_oe_o(dev_oe));
  function automatic logic [15:0] word_of(input logic [17:0] a);
    return shadow.exists(a) ? shadow[a] : 16'h0000;
  endfunction : word_of
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic do_op(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] ln);
    logic [15:0] m;
    int          n;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_i <= '{addr: a, wdata: d, write: wr, lanes: ln};
    n = 0;
    do begin @(posedge clock_i); n++; end while (req_ready_o !== 1'b1 && n < 300);
    `CHECK(req_ready_o, 1'b1)
    req_valid_i <= 1'b0;
    if (wr) shadow[a] = (word_of(a) & ~m) | (d & m);
    else begin
      n = 0;
      do begin @(posedge clock_i); n++; end while (rsp_valid_o !== 1'b1 && n < 20);
      `CHECK(rsp_valid_o, 1'b1)
      `CHECK(rsp_data_o, word_of(a) & m)
    end
  endtask : do_op
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    logic [1:0] ln;
    repeat (2) @(posedge clock_i);
    power_good_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    do_op(1'b1, 18'h3ffff, 16'hbeef, 2'b11);
    do_op(1'b1, 18'h3ffff, 16'h1200, 2'b10);
    do_op(1'b0, 18'h3ffff, 16'h0000, 2'b11);
    do_op(1'b0, 18'h3ffff, 16'h0000, 2'b01);
    for (int i = 0; i < 60; i++) begin
      ln = 2'($random(seed));
      if (ln == 2'b00) ln = 2'b11;
      do_op(1'($random(seed)), {15'h0000, 3'($random(seed))}, 16'($random(seed)), ln);
    end
    // The second power cycle follows no write, so no save is due.
    repeat (2) begin
      // A write still in flight would be cut by the supply drop, so let the controller go idle first.
      do @(posedge clock_i); while (req_ready_o !== 1'b1);
      power_good_i <= 1'b0;
      repeat (40) @(posedge clock_i);
      `CHECK(mem_busy_o, 1'b1)
      power_good_i <= 1'b1;
      for (int i = 0; i < 8; i++) do_op(1'b0, 18'(i), 16'h0000, 2'b11);
    end
    summarize();
  end
endmodule : sram_host_ctrl_bench
